// ==== src/ddrpi_buf_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ddrpi_buf_if #(parameter int W = 16);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : ddrpi_buf_if
`default_nettype wire

// ==== src/ddrpi_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddrpi_core (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_link_clk,
    input wire logic i_chip_select_n,
    input wire logic i_row_strobe_n,
    input wire logic i_col_strobe_n,
    input wire logic i_write_en_n,
    input wire logic [ddrpi_pkg::BANK_W-1:0] i_bank_select_bits,
    input wire logic [ddrpi_pkg::ADDR_W-1:0] i_address_bus,
    input wire logic i_termination_enable,
    input wire logic [ddrpi_pkg::DQ_W-1:0] i_data_lines,
    input wire logic i_lower_byte_strobe,
    input wire logic i_upper_byte_strobe,
    output logic [ddrpi_pkg::DQ_W-1:0] o_data_lines,
    output logic [1:0] o_data_lines_oe,
    output logic o_lower_byte_strobe,
    output logic o_lower_byte_strobe_oe,
    output logic o_lower_byte_strobe_n,
    output logic o_lower_byte_strobe_n_oe,
    output logic o_upper_byte_strobe,
    output logic o_upper_byte_strobe_oe,
    output logic o_upper_byte_strobe_n,
    output logic o_upper_byte_strobe_n_oe,
    output logic o_termination_active,
    output logic [ddrpi_pkg::NBANK-1:0] o_bank_open
);
    localparam int SW = 1 + 4 + ddrpi_pkg::BANK_W + ddrpi_pkg::ADDR_W + 1 + 2 + ddrpi_pkg::DQ_W;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_BURST = 2'b10} ddrpi_rd_e;
    function automatic logic [ddrpi_pkg::IDX_W-1:0] mem_index(
        input logic [ddrpi_pkg::BANK_W-1:0] bank,
        input logic [ddrpi_pkg::COL_IDX_W-1:0] col,
        input logic [1:0] beat
    );
        mem_index = {bank, col + ddrpi_pkg::COL_IDX_W'(beat)};
    endfunction : mem_index

    // Every pin crosses in from the link side, so all pass two flops
    logic [SW-1:0] meta;
    logic [SW-1:0] sync;
    logic s_link;
    logic s_cs_n;
    logic [2:0] s_cmd;
    logic [ddrpi_pkg::BANK_W-1:0] s_ba;
    logic [ddrpi_pkg::ADDR_W-1:0] s_addr;
    logic s_odt;
    logic [1:0] s_strobe;
    logic [ddrpi_pkg::DQ_W-1:0] s_dq;
    logic link_prev;
    logic link_rise;
    logic link_edge;
    logic cmd_take;
    logic [1:0] strobe_prev;
    logic [1:0] strobe_edge;
    logic [ddrpi_pkg::NBANK-1:0] bank_open;
    logic diff_strobe;
    ddrpi_rd_e rd_state;
    logic [ddrpi_pkg::BANK_W-1:0] rd_bank;
    logic [ddrpi_pkg::COL_IDX_W-1:0] rd_col;
    logic [1:0] rd_beat;
    logic [1:0] wr_active;
    logic [ddrpi_pkg::BANK_W-1:0] wr_bank;
    logic [ddrpi_pkg::COL_IDX_W-1:0] wr_col;
    logic [1:0] wr_beat [2];
    logic [ddrpi_pkg::LANE_W-1:0] lane_mem [2][1 << ddrpi_pkg::IDX_W];
    logic [1:0] strobe_q;
    logic [1:0] lane_oe;
    logic [ddrpi_pkg::DQ_W-1:0] dq_q;
    logic [ddrpi_pkg::IDX_W-1:0] rd_idx;
    logic [1:0] strobe_n_q;
    logic [1:0] n_oe_q;
    ddrpi_buf_if #(.W(ddrpi_pkg::DQ_W)) rbuf ();
    ddrpi_fifo #(.W(ddrpi_pkg::DQ_W), .DEPTH(ddrpi_pkg::BUF_DEPTH)) u_rbuf (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .bus(rbuf.store)
    );

    always_ff @(posedge i_clk) begin
        meta <= {i_link_clk, i_chip_select_n, i_row_strobe_n, i_col_strobe_n, i_write_en_n,
                 i_bank_select_bits, i_address_bus, i_termination_enable,
                 i_upper_byte_strobe, i_lower_byte_strobe, i_data_lines};
        sync <= meta;
    end
    assign {s_link, s_cs_n, s_cmd, s_ba, s_addr, s_odt, s_strobe, s_dq} = sync;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            link_prev <= s_link; // Track pins in reset so release shows no false edge
            strobe_prev <= s_strobe;
        end else begin
            link_prev <= s_link;
            strobe_prev <= s_strobe;
        end
    end
    assign link_rise = s_link & ~link_prev;
    assign link_edge = s_link ^ link_prev;
    assign cmd_take = link_rise & ~s_cs_n;
    assign strobe_edge = s_strobe ^ strobe_prev;

    // Bank state and extended register one; a closed bank drops reads and writes
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bank_open <= ddrpi_pkg::BANK_OPEN_RST;
            diff_strobe <= ddrpi_pkg::DIFF_STROBE_RST;
        end else if (cmd_take) begin
            case (s_cmd)
                ddrpi_pkg::CMD_ACT: bank_open[s_ba] <= 1'b1;
                ddrpi_pkg::CMD_PRE: begin
                    if (s_addr[ddrpi_pkg::AP_BIT]) begin
                        bank_open <= '0;
                    end else begin
                        bank_open[s_ba] <= 1'b0;
                    end
                end
                ddrpi_pkg::CMD_RD, ddrpi_pkg::CMD_WR: begin
                    if (s_addr[ddrpi_pkg::AP_BIT]) begin
                        bank_open[s_ba] <= 1'b0;
                    end
                end
                ddrpi_pkg::CMD_MRS: begin
                    if (s_ba == ddrpi_pkg::EMR1_BANK) begin
                        // Low level on A10 selects the complement strobes
                        diff_strobe <= ~s_addr[ddrpi_pkg::AP_BIT];
                    end
                end
                default: ;
            endcase
        end
    end

    // Read burst feeds the buffer; a full buffer stalls the burst
    assign rd_idx = mem_index(rd_bank, rd_col, rd_beat);
    assign rbuf.in_valid = (rd_state == RD_BURST);
    assign rbuf.in_data = {lane_mem[1][rd_idx], lane_mem[0][rd_idx]};
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rd_state <= RD_IDLE;
            rd_bank <= '0;
            rd_col <= '0;
            rd_beat <= ddrpi_pkg::BEAT_RST;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    if (cmd_take && s_cmd == ddrpi_pkg::CMD_RD && bank_open[s_ba]) begin
                        rd_bank <= s_ba;
                        rd_col <= s_addr[ddrpi_pkg::COL_IDX_W-1:0];
                        rd_beat <= ddrpi_pkg::BEAT_RST;
                        rd_state <= RD_BURST;
                    end
                end
                RD_BURST: begin
                    if (rbuf.in_ready) begin
                        rd_beat <= rd_beat + 2'h1;
                        if (rd_beat == 2'(ddrpi_pkg::BURST_LEN - 1)) begin
                            rd_state <= RD_IDLE;
                        end
                    end
                end
                default: rd_state <= RD_IDLE;
            endcase
        end
    end

    // Write capture: each lane counts beats on its own strobe edges
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_active <= 2'h0;
            wr_bank <= '0;
            wr_col <= '0;
            wr_beat[0] <= ddrpi_pkg::BEAT_RST;
            wr_beat[1] <= ddrpi_pkg::BEAT_RST;
        end else if (cmd_take && s_cmd == ddrpi_pkg::CMD_WR && bank_open[s_ba]) begin
            wr_active <= 2'h3;
            wr_bank <= s_ba;
            wr_col <= s_addr[ddrpi_pkg::COL_IDX_W-1:0];
            wr_beat[0] <= ddrpi_pkg::BEAT_RST;
            wr_beat[1] <= ddrpi_pkg::BEAT_RST;
        end else if (cmd_take && s_cmd == ddrpi_pkg::CMD_RD) begin
            wr_active <= 2'h0; // A read ends a short write, so looped-back read strobes store nothing
        end else begin
            for (int l = 0; l < 2; l++) begin
                if (wr_active[l] && strobe_edge[l]) begin
                    wr_beat[l] <= wr_beat[l] + 2'h1;
                    if (wr_beat[l] == 2'(ddrpi_pkg::BURST_LEN - 1)) begin
                        wr_active[l] <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        for (int l = 0; l < 2; l++) begin
            if (wr_active[l] && strobe_edge[l]) begin
                lane_mem[l][mem_index(wr_bank, wr_col, wr_beat[l])] <=
                    s_dq[l*ddrpi_pkg::LANE_W +: ddrpi_pkg::LANE_W];
            end
        end
    end

    // Drive side: data and strobe change on the same link edge
    assign rbuf.out_ready = link_edge;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dq_q <= '0;
            strobe_q <= 2'h0;
            strobe_n_q <= 2'h3;
            lane_oe <= 2'h0;
            n_oe_q <= 2'h0;
        end else if (link_edge) begin
            if (rbuf.out_valid) begin
                dq_q <= rbuf.out_data;
                strobe_q <= ~strobe_q;
                strobe_n_q <= strobe_q;
                lane_oe <= 2'h3;
                n_oe_q <= {2{diff_strobe}};
            end else begin
                strobe_q <= 2'h0;
                strobe_n_q <= 2'h3;
                lane_oe <= 2'h0;
                n_oe_q <= 2'h0;
            end
        end else if (!diff_strobe) begin
            n_oe_q <= 2'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_termination_active <= 1'b0;
        end else if (link_rise) begin
            o_termination_active <= s_odt;
        end
    end

    assign o_data_lines = dq_q;
    assign o_data_lines_oe = lane_oe;
    assign o_lower_byte_strobe = strobe_q[0];
    assign o_upper_byte_strobe = strobe_q[1];
    assign o_lower_byte_strobe_oe = lane_oe[0];
    assign o_upper_byte_strobe_oe = lane_oe[1];
    assign o_lower_byte_strobe_n = strobe_n_q[0];
    assign o_upper_byte_strobe_n = strobe_n_q[1];
    assign o_lower_byte_strobe_n_oe = n_oe_q[0];
    assign o_upper_byte_strobe_n_oe = n_oe_q[1];
    assign o_bank_open = bank_open;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_read_open;
        cmd_take && s_cmd == ddrpi_pkg::CMD_RD && bank_open[s_ba] && rd_state == RD_IDLE;
    endsequence
    sequence s_burst_runs;
        rd_state == RD_BURST [*1] ##[1:40] rd_state == RD_IDLE;
    endsequence

    a_cs_masks_cmd: assert property (link_rise && s_cs_n |=> $stable(bank_open) && $stable(diff_strobe))
        else $error("command taken with chip select high");
    a_sample_rise: assert property ($changed(bank_open) |-> $past(link_rise))
        else $error("bank state changed off a rising link edge");
    a_act_one_bank: assert property (cmd_take && s_cmd == ddrpi_pkg::CMD_ACT |=>
        bank_open == ($past(bank_open) | (8'h01 << $past(s_ba))))
        else $error("activate touched other banks");
    a_ap_closes: assert property (cmd_take && s_cmd == ddrpi_pkg::CMD_RD && s_addr[ddrpi_pkg::AP_BIT]
        |=> !bank_open[$past(s_ba)])
        else $error("auto-precharge left bank open");
    a_read_burst: assert property (s_read_open |=> rd_col == $past(s_addr[2:0]) ##0 s_burst_runs)
        else $error("read burst column or length wrong");
    a_strobe_data: assert property (link_edge && rbuf.out_valid |=> strobe_q != $past(strobe_q)
        && dq_q == $past(rbuf.out_data))
        else $error("read strobe not aligned to data change");
    a_diff_gate: assert property (!diff_strobe |=> !o_lower_byte_strobe_n_oe && !o_upper_byte_strobe_n_oe)
        else $error("complement strobe driven in single-ended mode");
    a_lane_indep: assert property (wr_active[1] && strobe_edge[0] && !strobe_edge[1] && !cmd_take
        |=> $stable(wr_beat[1]))
        else $error("lower strobe advanced the upper lane");
    a_odt_follow: assert property (link_rise |=> o_termination_active == $past(s_odt))
        else $error("termination did not follow its enable");
    a_strobe_with_data: assert property (o_data_lines_oe[0] == o_lower_byte_strobe_oe)
        else $error("lane data driven without its strobe");
endmodule : ddrpi_core
`default_nettype wire

// ==== src/ddrpi_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddrpi_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_srst,
    ddrpi_buf_if.store bus
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign bus.in_ready = (count != (PW+1)'(DEPTH));
    assign bus.out_valid = (count != '0);
    assign bus.out_data = mem[rd_ptr];
    assign push = bus.in_valid & bus.in_ready;
    assign pop = bus.out_valid & bus.out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= bus.in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_fifo_no_overrun: assert property (bus.in_valid && !bus.in_ready
        |=> count == $past(count) - (PW+1)'($past(pop)))
        else $error("buffer count moved while full");
endmodule : ddrpi_fifo
`default_nettype wire

// ==== src/ddrpi_pkg.sv ====
package ddrpi_pkg;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 3;
    localparam int NBANK = 8;
    localparam int DQ_W = 16;
    localparam int LANE_W = 8;
    localparam int COL_IDX_W = 3;
    localparam int IDX_W = BANK_W + COL_IDX_W;
    localparam int BURST_LEN = 4;
    localparam int AP_BIT = 10;
    localparam int BUF_DEPTH = 2;
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] EMR1_BANK = 3'h1;
    localparam logic [NBANK-1:0] BANK_OPEN_RST = 8'h00;
    localparam logic DIFF_STROBE_RST = 1'b0;
    localparam logic [1:0] BEAT_RST = 2'h0;
endpackage : ddrpi_pkg

// ==== test/ddrpi_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddrpi_ctrl_model (
    output logic o_link_clk,
    output logic o_cs_n,
    output logic [2:0] o_cmd_n,
    output logic [ddrpi_pkg::BANK_W-1:0] o_ba,
    output logic [ddrpi_pkg::ADDR_W-1:0] o_addr,
    output logic o_odt,
    output logic [ddrpi_pkg::DQ_W-1:0] o_dq,
    output logic [1:0] o_dqs
);
    // Device clock runs freely; odd offset keeps its edges off the system clock edges
    initial begin
        o_link_clk = 1'b0;
        #37;
        forever #400 o_link_clk = ~o_link_clk;
    end
    initial begin
        o_cs_n = 1'b1;
        o_cmd_n = 3'h7;
        o_ba = 3'h0;
        o_addr = 13'h0000;
        o_odt = 1'b0;
        o_dq = 16'h0000;
        o_dqs = 2'h0;
    end
    // Pins change at link fall, half a period clear of the sampling rise
    task automatic cmd(input logic cs_n, input logic [2:0] code, input logic [2:0] ba,
            input logic [12:0] addr, input logic termination_enable, input logic [31:0] junk);
        @(negedge o_link_clk);
        o_cs_n = cs_n;
        o_cmd_n = code;
        o_ba = ba;
        o_addr = addr;
        o_odt = termination_enable;
        @(negedge o_link_clk);
        o_cs_n = 1'b1;
        o_cmd_n = junk[2:0];
        o_ba = junk[5:3];
        o_addr = junk[18:6];
    endtask : cmd
    // One word per link period; strobe flips mid-eye on the selected lanes only
    task automatic burst(input logic [1:0] lanes, input int beats, input logic [79:0] w);
        @(negedge o_link_clk);
        for (int i = 0; i < beats; i++) begin
            o_dq = w[16*i +: 16];
            @(posedge o_link_clk);
            o_dqs = o_dqs ^ lanes;
            @(negedge o_link_clk);
        end
        o_dq = ~o_dq;
    endtask : burst
endmodule : ddrpi_ctrl_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic lk, cs_n, termination_enable, ls, ls_oe, ls_n_oe, us, us_oe, us_n_oe, term, ls_n, us_n;
    logic [2:0] cmd_n, ba;
    logic [12:0] addr;
    logic [15:0] pdq, rd;
    logic [1:0] pdqs, dq_oe;
    logic [7:0] bank_open, open_exp;
    logic [15:0] mem [64];
    logic [15:0] rq [$];
    logic diff = 1'b0;
    logic ls_q = 1'b0;
    logic [15:0] rd_q = 16'h0000;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    integer seed = 32'hc305;
    wire [15:0] dq_w = {dq_oe[1] ? rd[15:8] : pdq[15:8], dq_oe[0] ? rd[7:0] : pdq[7:0]};
    wire ls_w = ls_oe ? ls : pdqs[0];
    wire us_w = us_oe ? us : pdqs[1];

    always #50 i_clk = ~i_clk;

    ddrpi_ctrl_model u_ddrpi_ctrl_model (.o_link_clk(lk), .o_cs_n(cs_n), .o_cmd_n(cmd_n),
        .o_ba(ba), .o_addr(addr), .o_odt(termination_enable), .o_dq(pdq), .o_dqs(pdqs));
    ddrpi_core u_ddrpi_core (.i_clk(i_clk), .i_srst(i_srst), .i_link_clk(lk),
        .i_chip_select_n(cs_n), .i_row_strobe_n(cmd_n[2]), .i_col_strobe_n(cmd_n[1]),
        .i_write_en_n(cmd_n[0]), .i_bank_select_bits(ba), .i_address_bus(addr),
        .i_termination_enable(termination_enable), .i_data_lines(dq_w), .i_lower_byte_strobe(ls_w),
        .i_upper_byte_strobe(us_w), .o_data_lines(rd), .o_data_lines_oe(dq_oe),
        .o_lower_byte_strobe(ls), .o_lower_byte_strobe_oe(ls_oe), .o_lower_byte_strobe_n(ls_n),
        .o_lower_byte_strobe_n_oe(ls_n_oe), .o_upper_byte_strobe(us),
        .o_upper_byte_strobe_oe(us_oe), .o_upper_byte_strobe_n(us_n),
        .o_upper_byte_strobe_n_oe(us_n_oe), .o_termination_active(term),
        .o_bank_open(bank_open));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // Read words are collected wherever the strobe flips
    always @(posedge i_clk) begin
        if (!i_srst && ls_oe) begin
            if (ls !== ls_q)
                rq.push_back(rd);
            else
                check(rd, rd_q, "read data moved off strobe edge");
            check(us, ls, "upper strobe");
            check({us_oe, dq_oe}, {ls_oe, 2'h3}, "lane enables");
            check({ls_n_oe, us_n_oe}, {2{diff}}, "complement enables");
            check({ls_n, us_n}, {~ls, ~us}, "complement strobes");
        end
        ls_q <= ls;
        rd_q <= rd;
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            summarize();
        end
    end

    function automatic logic [12:0] mk_addr(input logic ap, input logic [2:0] col);
        logic [31:0] a;
        a = $random(seed);
        return {a[12:11], ap, a[9:3], col};
    endfunction : mk_addr

    task automatic issue(input logic cs, input logic [2:0] code, input logic [2:0] b,
            input logic [12:0] a);
        logic [31:0] r;
        r = $random(seed);
        u_ddrpi_ctrl_model.cmd(cs, code, b, a, r[31], r);
        if (!cs) begin
            case (code)
                ddrpi_pkg::CMD_ACT: open_exp[b] = 1'b1;
                ddrpi_pkg::CMD_PRE: open_exp = a[10] ? 8'h00 : open_exp & ~(8'h01 << b);
                ddrpi_pkg::CMD_RD, ddrpi_pkg::CMD_WR: if (a[10]) open_exp[b] = 1'b0;
                ddrpi_pkg::CMD_MRS: if (b == ddrpi_pkg::EMR1_BANK) diff = ~a[10];
                default: ;
            endcase
        end
        repeat (3) @(posedge i_clk);
        check(term, r[31], "termination");
        check(bank_open, open_exp, "open banks");
    endtask : issue

    task automatic wr(input logic [2:0] b, input logic [2:0] col, input logic [1:0] lanes,
            input int beats);
        logic [79:0] w;
        logic [5:0] k;
        for (int i = 0; i < 5; i++)
            w[16*i +: 16] = 16'($random(seed));
        for (int i = 0; i < 4 && i < beats; i++) begin
            k = {b, col + 3'(i)};
            if (lanes[0]) mem[k][7:0] = w[16*i +: 8];
            if (lanes[1]) mem[k][15:8] = w[16*i+8 +: 8];
        end
        issue(1'b0, ddrpi_pkg::CMD_WR, b, mk_addr(1'b0, col));
        u_ddrpi_ctrl_model.burst(lanes, beats, w);
    endtask : wr

    task automatic rd_check(input logic [2:0] b, input logic [2:0] col, input logic ap,
            input int n);
        rq.delete();
        issue(1'b0, ddrpi_pkg::CMD_RD, b, mk_addr(ap, col));
        for (int i = 0; i < 80 && rq.size() < 4; i++)
            @(posedge i_clk);
        check(rq.size(), n, "burst length");
        for (int i = 0; i < n && i < rq.size(); i++)
            check(rq[i], mem[{b, col + 3'(i)}], "read word");
    endtask : rd_check

    initial begin
        open_exp = 8'h00;
        repeat (12) @(negedge i_clk);
        i_srst = 1'b0;
        check(bank_open, ddrpi_pkg::BANK_OPEN_RST, "reset banks");
        check({term, dq_oe, ls_oe}, 4'h0, "reset drive");
        for (int b = 0; b < 8; b++) begin
            issue(1'b0, ddrpi_pkg::CMD_ACT, 3'(b), mk_addr(1'b0, 3'h0));
            wr(3'(b), 3'h0, 2'h3, 4);
            wr(3'(b), 3'h4, 2'h3, 4);
        end
        $display("test fill done");
        for (int b = 0; b < 8; b++)
            rd_check(3'(b), 3'($random(seed)), 1'b0, 4);
        rd_check(3'h2, 3'h7, 1'b0, 4);
        $display("test random reads done");
        // Fifth strobe flip must be dropped; the idle lane keeps its bytes
        wr(3'h0, 3'h2, 2'h1, 5);
        wr(3'h0, 3'h6, 2'h2, 4);
        rd_check(3'h0, 3'h2, 1'b0, 4);
        rd_check(3'h0, 3'h6, 1'b0, 4);
        $display("test lanes done");
        issue(1'b1, ddrpi_pkg::CMD_PRE, 3'h0, mk_addr(1'b1, 3'h0));
        issue(1'b0, ddrpi_pkg::CMD_PRE, 3'h3, mk_addr(1'b0, 3'h0));
        rd_check(3'h3, 3'h0, 1'b0, 0);
        rd_check(3'h5, 3'h1, 1'b1, 4);
        rd_check(3'h5, 3'h1, 1'b0, 0);
        issue(1'b0, ddrpi_pkg::CMD_WR, 3'h4, mk_addr(1'b1, 3'h0));
        rd_check(3'h4, 3'h0, 1'b0, 0);
        $display("test select and precharge done");
        issue(1'b0, ddrpi_pkg::CMD_MRS, ddrpi_pkg::EMR1_BANK, mk_addr(1'b0, 3'h0));
        rd_check(3'h6, 3'h3, 1'b0, 4);
        issue(1'b0, ddrpi_pkg::CMD_MRS, ddrpi_pkg::EMR1_BANK, mk_addr(1'b1, 3'h0));
        rd_check(3'h6, 3'h3, 1'b0, 4);
        issue(1'b0, ddrpi_pkg::CMD_PRE, 3'h0, mk_addr(1'b1, 3'h0));
        $display("test strobe mode done");
        summarize();
    end
endmodule : tb
`default_nettype wire
